/* File: dv/agc_conv_model.sv */
// gain error converter model: busy level and error word per conversion
// assumes start is a one-cycle pulse from the bench, synchronous to pclk
`default_nettype none
module agc_conv_model #(
	parameter CONV = 60
) (
	input  wire logic       pclk,
	input  wire logic       start,
	input  wire logic [7:0] err_in,
	output var  logic [7:0] err_out,
	output var  logic       done
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	initial begin
		err_out = 8'h00;
		done = 1'b0;
	end
	// word is not valid mid-conversion, so it is scrambled until done
	always @(posedge pclk) begin
		if (start) begin
			done <= 1'b1;
			err_out <= ~err_out;
			n <= CONV;
		end else if (n == 1) begin
			done <= 1'b0;
			err_out <= err_in;
			n <= 0;
		end else if (n > 0) begin
			n <= n - 1;
		end
	end
endmodule // agc_conv_model
`default_nettype wire

/* File: dv/agc_ctrl_assertions.sv */
// port checker for agc_ctrl: apb timing, sample pulses, conversion flag
// assumes one pclk domain and presetn active low
`default_nettype none
module agc_ctrl_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       gain_conv_done,
	input wire logic       gain_hold_n,
	input wire logic [1:0] chan_track,
	input wire logic [1:0] chan_search,
	input wire logic [1:0] gain_sample_pulse_n,
	input wire logic       gain_conv_done_dly_n,
	input wire logic       min_gain_flag,
	input wire logic       drop_track
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] low_cnt;
	// counts low cycles of channel one pulse; wraps are harmless at 20
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_cnt <= 8'h00;
		else
			low_cnt <= gain_sample_pulse_n[0] ? 8'h00 : low_cnt + 8'h01;
	end
	a_pulse_len: assert property (
		$rose(gain_sample_pulse_n[0]) |-> low_cnt == 8'h14)
		else $error("sample pulse length wrong");
	a_hold_blocks: assert property (
		$fell(gain_sample_pulse_n[0]) |-> $past(gain_hold_n, 3))
		else $error("sample pulse while held");
	a_track_only: assert property (
		$fell(gain_sample_pulse_n[1]) |->
		$past(chan_track[1], 3) && !$past(chan_search[1], 3))
		else $error("sample pulse outside track");
	a_flag_clear: assert property (
		$fell(gain_conv_done_dly_n) |-> ##[0:2] !min_gain_flag)
		else $error("flag not cleared by delayed done");
	a_dly_settle: assert property (
		$fell(gain_conv_done_dly_n) |-> $past(gain_conv_done, 40))
		else $error("delayed done too early");
	a_drop_flag: assert property (
		drop_track |-> min_gain_flag || $past(min_gain_flag))
		else $error("drop without flag");
	a_apb_wait: assert property (
		psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_ready_once: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule // agc_ctrl_chk
bind agc_ctrl agc_ctrl_chk i_agc_ctrl_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.gain_conv_done(gain_conv_done), .gain_hold_n(gain_hold_n),
	.chan_track(chan_track), .chan_search(chan_search),
	.gain_sample_pulse_n(gain_sample_pulse_n),
	.gain_conv_done_dly_n(gain_conv_done_dly_n),
	.min_gain_flag(min_gain_flag), .drop_track(drop_track));
`default_nettype wire

/* File: dv/agc_ctrl_tb.sv */
// self-checking bench for agc_ctrl: apb master, converter model, gains
// assumes one apb wait state and gain registers reset to 0x10
`include "agc_map.vh"
`default_nettype none
module agc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  gerr;
	logic [7:0]  err_in = 8'h00;
	logic        done;
	logic        start = 1'b0;
	logic [7:0]  preset = 8'h40;
	logic        hold_n = 1'b1;
	logic [1:0]  trk = 2'h3;
	logic [1:0]  srch = 2'h0;
	logic [1:0]  xsel = 2'h1;
	logic        acq = 1'b0;
	logic [1:0]  req = 2'h0;
	logic [7:0]  rx_word;
	logic        flag;
	logic        drop;
	logic [31:0] r;
	logic        e;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          lvl [2] = '{16, 16};
	int          t;
	agc_ctrl i_agc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gain_error(gerr), .gain_conv_done(done),
		.search_gain_preset(preset), .gain_hold_n(hold_n),
		.chan_track(trk), .chan_search(srch),
		.extended_channel_select(xsel), .acquisition(acq),
		.sample_req(req), .receiver_gain_word(rx_word),
		.gain_sample_pulse_n(), .gain_conv_done_dly_n(),
		.min_gain_flag(flag), .drop_track(drop));
	agc_conv_model i_agc_conv_model (.pclk(pclk), .start(start),
		.err_in(err_in), .err_out(gerr), .done(done));
	always #5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		chk(pready, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	// one conversion, then one sample request on channel c
	task automatic upd(input int c, input int er, input bit stp);
		int v;
		int i;
		xsel <= c ? 2'h2 : 2'h1;
		err_in <= er[7:0];
		apb(1'b1, `AGC_OFF_CTRL, {31'h0, stp});
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		for (i = 0; i < 200 && (i < 3 || done !== 1'b0); i++)
			@(posedge pclk);
		chk(done, 32'h0);
		repeat (60) @(posedge pclk);
		req <= c ? 2'h2 : 2'h1;
		repeat (30) @(posedge pclk);
		req <= 2'h0;
		v = lvl[c] + er;
		if (stp && !acq)
			v = er < 0 ? (lvl[c] <= 16 ? lvl[c] : lvl[c] - 1) : lvl[c] + 1;
		if (!stp) begin
			chk(flag, v < 16);
			chk(drop, v < 16);
		end
		if (hold_n)
			lvl[c] = v < 16 ? 16 : (v > 255 ? 255 : v);
		rd(c ? `AGC_OFF_GAIN2 : `AGC_OFF_GAIN1, lvl[c]);
		chk(rx_word, lvl[0]);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_sim;
	end
	initial begin
		t = $urandom(99);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`AGC_OFF_MINREF, 32'h10);
		rd(`AGC_OFF_CTRL, 32'h0);
		apb(1'b1, `AGC_OFF_GAIN1, 32'hFF);
		rd(`AGC_OFF_GAIN1, 32'h10);
		apb(1'b0, 8'h1C, 32'h0);
		chk(e, 1'b1);
		$display("test registers done");
		upd(0, 5, 0);
		upd(1, -3, 0);
		upd(0, 7, 1);
		upd(0, -9, 1);
		upd(1, -4, 1);
		acq <= 1'b1;
		upd(0, 7, 1);
		acq <= 1'b0;
		hold_n <= 1'b0;
		upd(0, 2, 0);
		hold_n <= 1'b1;
		$display("test fixed updates done");
		repeat (6)
			upd($urandom % 2, int'($urandom % 201) - 100, 0);
		$display("test random updates done");
		preset <= 8'($urandom);
		srch <= 2'h1;
		xsel <= 2'h1;
		req[0] <= 1'b1;
		repeat (100) @(posedge pclk);
		lvl[0] = preset;
		rd(`AGC_OFF_GAIN1, lvl[0]);
		apb(1'b0, `AGC_OFF_STATUS, 32'h0);
		chk(r[5:1], 5'h14);
		srch <= 2'h0;
		req[0] <= 1'b0;
		$display("test search done");
		apb(1'b1, `AGC_OFF_CTRL, 32'h2);
		repeat (4) @(posedge pclk);
		chk(rx_word, lvl[1]);
		apb(1'b1, `AGC_OFF_LUTADDR, lvl[1]);
		apb(1'b1, `AGC_OFF_LUTDATA, 32'hA5);
		apb(1'b1, `AGC_OFF_CTRL, 32'h6);
		repeat (4) @(posedge pclk);
		chk(rx_word, 8'hA5);
		$display("test receiver select done");
		end_sim;
	end
endmodule // agc_ctrl_tb
`default_nettype wire

/* File: rtl/agc_ctrl.v */
// two-channel gain control: per-channel gain levels, error adder with
// minimum clamp and step mode, receiver level select through a lookup,
// registers over apb
// assumes the converter, switch and timing pins are asynchronous to pclk
//
// Implementation choices: the APB interface to the registers and the register addresses.
`include "agc_map.vh"
`default_nettype none

//Contract
//- new level equals stored level plus error
//- receiver channel select drives lookup then DAC
//- selector picks ch1, ch2, preset, minimum
//- preset search level comes from switches
//- sample updates only during track
//- done delayed 400 ns, inverted; edge clears flag
//- result not below minimum loads on sample
//- sample pulse active low, 200 ns
//- hold low suppresses sample pulses
//- below minimum sets flag, minimum gets stored
//- flag gated off during search
//- error signed, stored level never negative
//- 2.5 MHz strobe loads preset during search
//- select code 11 min, 10 preset, 0x channel
//- step mode changes by one step only
//- acquisition overrides step mode
//- adder: pass, add, plus one, minus one
//- below minimum in track drops track
module agc_ctrl #(
	parameter GW = 8,
	parameter EW = 8
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [7:0]    paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	input  wire [EW-1:0] gain_error,
	input  wire          gain_conv_done,
	input  wire [GW-1:0] search_gain_preset,
	input  wire          gain_hold_n,
	input  wire [1:0]    chan_track,
	input  wire [1:0]    chan_search,
	input  wire [1:0]    extended_channel_select,
	input  wire          acquisition,
	input  wire [1:0]    sample_req,
	output reg  [GW-1:0] receiver_gain_word,
	output wire [1:0]    gain_sample_pulse_n,
	output reg           gain_conv_done_dly_n,
	output reg           min_gain_flag,
	output reg           drop_track
);

	localparam SW = EW + GW + 11;
	localparam AW = GW + 2;
	localparam [15:0] EOC_CYC = `AGC_EOC_DLY_CYC;
	localparam [15:0] STB_CYC = `AGC_STROBE_CYC;

	// every converter, switch and timing pin passes two flops before use; apb pins are used directly
	reg  [SW-1:0]      sync1_r;
	reg  [SW-1:0]      sync2_r;
	wire [EW-1:0]      err_s;
	wire               done_s;
	wire [GW-1:0]      preset_s;
	wire               hold_n_s;
	wire [1:0]         track_s;
	wire [1:0]         search_s;
	wire [1:0]         xsel_s;
	wire               acq_s;
	wire [1:0]         req_s;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= {SW{1'b0}};
			sync2_r <= {SW{1'b0}};
		end else begin
			sync1_r <= {gain_error, gain_conv_done, search_gain_preset,
				gain_hold_n, chan_track, chan_search,
				extended_channel_select, acquisition, sample_req};
			sync2_r <= sync1_r;
		end
	end

	assign {err_s, done_s, preset_s, hold_n_s, track_s, search_s,
		xsel_s, acq_s, req_s} = sync2_r;

	// software state
	reg  [`AGC_CTRL_W-1:0] ctrl_r;
	reg  [GW-1:0]          min_gain_reference;
	reg  [GW-1:0]          lut_addr_r;
	reg  [GW-1:0]          lut [0:(1<<GW)-1];
	reg  [GW-1:0]          gain_r [0:1];

	// selector and adder
	wire               any_search_selected;
	wire               any_search_selected_n;
	wire               search_gate_n;
	wire               min_gain_gated_n;
	wire               min_gain_select_n;
	wire               selector_bit0;
	wire               selector_bit1;
	reg  [GW-1:0]      adder_input_a;
	reg  [AW-1:0]      sum_w;
	reg  [GW-1:0]      adder_result;
	reg                below_min_detect;
	wire [AW-1:0]      a_ext;
	wire [AW-1:0]      b_ext;
	wire [AW-1:0]      ref_ext;
	wire               err_neg;
	wire               step_mode;

	assign any_search_selected = |(search_s & xsel_s);
	assign any_search_selected_n = ~any_search_selected;
	assign search_gate_n = any_search_selected_n;
	// a flag left over from track would force the minimum over the preset during search
	assign min_gain_gated_n = ~(min_gain_flag & any_search_selected_n);
	assign min_gain_select_n = min_gain_gated_n;
	assign selector_bit1 = ~search_gate_n | ~min_gain_select_n;
	assign selector_bit0 = (search_gate_n & xsel_s[1]) | ~min_gain_select_n;

	always @* begin
		case ({selector_bit1, selector_bit0})
		2'b00:   adder_input_a = gain_r[0];
		2'b01:   adder_input_a = gain_r[1];
		2'b10:   adder_input_a = preset_s;
		default: adder_input_a = min_gain_reference;
		endcase
	end

	assign a_ext = {2'b00, adder_input_a};
	assign ref_ext = {2'b00, min_gain_reference};
	assign err_neg = err_s[EW-1];
	// two's complement error, widened with its sign
	generate
		if (EW >= AW) begin : g_bnar
			assign b_ext = err_s[AW-1:0];
		end else begin : g_bext
			assign b_ext = {{(AW-EW){err_neg}}, err_s};
		end
	endgenerate
	assign step_mode = ctrl_r[`AGC_CTRL_LSB] & ~acq_s;

	always @* begin
		if (selector_bit1) begin
			sum_w = a_ext;
		end else if (!step_mode) begin
			sum_w = a_ext + b_ext;
		end else if (!err_neg) begin
			sum_w = a_ext + {{(AW-1){1'b0}}, 1'b1};
		end else if (a_ext > ref_ext) begin
			sum_w = a_ext - {{(AW-1){1'b0}}, 1'b1};
		end else begin
			sum_w = a_ext;
		end
		// top bit set means the sum went negative
		below_min_detect = sum_w[AW-1] | (sum_w < ref_ext);
		if (sum_w[AW-1]) begin
			adder_result = min_gain_reference;
		end else if (sum_w[AW-2]) begin
			adder_result = {GW{1'b1}};
		end else begin
			adder_result = sum_w[GW-1:0];
		end
	end

	// conversion done delayed by a settle counter, then inverted
	reg                done_dly_r;
	reg  [15:0]        eoc_cnt_r;
	reg                track_sel;

	always @* begin
		track_sel = |(track_s & xsel_s);
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_dly_r <= 1'b0;
			eoc_cnt_r <= 16'h0000;
			gain_conv_done_dly_n <= 1'b1;
		end else begin
			gain_conv_done_dly_n <= ~done_dly_r;
			if (done_s == done_dly_r) begin
				eoc_cnt_r <= 16'h0000;
			end else if (eoc_cnt_r == EOC_CYC - 16'h0001) begin
				done_dly_r <= done_s;
				eoc_cnt_r <= 16'h0000;
			end else begin
				eoc_cnt_r <= eoc_cnt_r + 16'h0001;
			end
		end
	end

	// flag: cleared as delayed done_n falls, set once error has settled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			min_gain_flag <= 1'b0;
			drop_track <= 1'b0;
		end else begin
			if (gain_conv_done_dly_n & done_dly_r) begin
				min_gain_flag <= 1'b0;
			end else if (!gain_conv_done_dly_n & !done_dly_r &
				below_min_detect & track_sel) begin
				min_gain_flag <= 1'b1;
			end
			drop_track <= min_gain_flag & any_search_selected_n &
				track_sel;
		end
	end

	// search strobe divider
	reg  [15:0]        stb_cnt_r;
	reg                search_strobe;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stb_cnt_r <= 16'h0000;
			search_strobe <= 1'b0;
		end else if (stb_cnt_r == STB_CYC - 16'h0001) begin
			stb_cnt_r <= 16'h0000;
			search_strobe <= 1'b1;
		end else begin
			stb_cnt_r <= stb_cnt_r + 16'h0001;
			search_strobe <= 1'b0;
		end
	end

	// per-channel sample pulse and register load
	reg  [1:0]         req_d_r;
	wire [1:0]         samp_done;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_d_r <= 2'b00;
		end else begin
			req_d_r <= req_s;
		end
	end

	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_ch
			wire trig;
			// hold checked at the request so the pulse never starts
			assign trig = req_s[c] & ~req_d_r[c] & track_s[c] &
				~search_s[c] & hold_n_s;

			agc_pulse #(
				.LEN (`AGC_SAMPLE_CYC)
			) u_pulse (
				.pclk    (pclk),
				.presetn (presetn),
				.trig    (trig),
				.pulse_n (gain_sample_pulse_n[c]),
				.done    (samp_done[c])
			);

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gain_r[c] <= `AGC_MINREF_RST;
				end else if (search_strobe & search_s[c]) begin
					gain_r[c] <= preset_s;
				end else if (samp_done[c] & track_s[c] & ~search_s[c]) begin
					if (below_min_detect) begin
						gain_r[c] <= min_gain_reference;
					end else begin
						gain_r[c] <= adder_result;
					end
				end
			end
		end
	endgenerate

	// receiver level through the linearizer
	wire [GW-1:0]      rx_level;

	assign rx_level = ctrl_r[`AGC_CTRL_RXCH2] ? gain_r[1] : gain_r[0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receiver_gain_word <= {GW{1'b0}};
		end else if (ctrl_r[`AGC_CTRL_LUTEN]) begin
			receiver_gain_word <= lut[rx_level];
		end else begin
			receiver_gain_word <= rx_level;
		end
	end

	// apb slave, one wait state; write and read data take effect as
	// pready is seen high
	reg                hit;
	reg  [31:0]        rd_w;
	wire               acc;
	wire               wr;

	assign acc = psel & penable;
	assign wr = acc & pready & pwrite;

	always @* begin
		hit = 1'b1;
		rd_w = 32'h00000000;
		case (paddr)
		`AGC_OFF_CTRL:    rd_w[`AGC_CTRL_W-1:0] = ctrl_r;
		`AGC_OFF_MINREF:  rd_w[GW-1:0] = min_gain_reference;
		`AGC_OFF_STATUS: begin
			rd_w[`AGC_ST_FLAG] = min_gain_flag;
			rd_w[`AGC_ST_GATED] = ~min_gain_gated_n;
			rd_w[`AGC_ST_DROP] = drop_track;
			rd_w[`AGC_ST_SRCH] = any_search_selected;
			rd_w[`AGC_ST_SEL0] = selector_bit0;
			rd_w[`AGC_ST_SEL1] = selector_bit1;
		end
		`AGC_OFF_GAIN1:   rd_w[GW-1:0] = gain_r[0];
		`AGC_OFF_GAIN2:   rd_w[GW-1:0] = gain_r[1];
		`AGC_OFF_LUTADDR: rd_w[GW-1:0] = lut_addr_r;
		`AGC_OFF_LUTDATA: rd_w[GW-1:0] = lut[lut_addr_r];
		default:          hit = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & ~hit;
			if (acc & ~pready & ~pwrite) begin
				prdata <= rd_w;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `AGC_CTRL_RST;
			min_gain_reference <= `AGC_MINREF_RST;
			lut_addr_r <= {GW{1'b0}};
		end else if (wr) begin
			case (paddr)
			`AGC_OFF_CTRL:    ctrl_r <= pwdata[`AGC_CTRL_W-1:0];
			`AGC_OFF_MINREF:  min_gain_reference <= pwdata[GW-1:0];
			`AGC_OFF_LUTADDR: lut_addr_r <= pwdata[GW-1:0];
			`AGC_OFF_LUTDATA: lut_addr_r <= lut_addr_r + {{(GW-1){1'b0}}, 1'b1};
			default:          lut_addr_r <= lut_addr_r;
			endcase
		end
	end

	// table has no reset; output bypasses it until enabled
	always @(posedge pclk) begin
		if (wr && paddr == `AGC_OFF_LUTDATA) begin
			lut[lut_addr_r] <= pwdata[GW-1:0];
		end
	end

endmodule // agc_ctrl

`default_nettype wire

/* File: rtl/agc_map.vh */
// register offsets, reset values and timing counts for the gain control
// assumes a 100 MHz pclk and byte addresses on an 8-bit apb address
`ifndef AGC_MAP_VH
`define AGC_MAP_VH

`define AGC_OFF_CTRL      8'h00
`define AGC_OFF_MINREF    8'h04
`define AGC_OFF_STATUS    8'h08
`define AGC_OFF_GAIN1     8'h0C
`define AGC_OFF_GAIN2     8'h10
`define AGC_OFF_LUTADDR   8'h14
`define AGC_OFF_LUTDATA   8'h18

`define AGC_CTRL_LSB      0
`define AGC_CTRL_RXCH2    1
`define AGC_CTRL_LUTEN    2
`define AGC_CTRL_W        3
`define AGC_CTRL_RST      3'h0
`define AGC_MINREF_RST    8'h10

`define AGC_ST_FLAG       0
`define AGC_ST_GATED      1
`define AGC_ST_DROP       2
`define AGC_ST_SRCH       3
`define AGC_ST_SEL0       4
`define AGC_ST_SEL1       5

`define AGC_CLK_MHZ       100
`define AGC_EOC_DLY_NS    400
`define AGC_EOC_DLY_CYC   ((`AGC_EOC_DLY_NS*`AGC_CLK_MHZ+999)/1000)
`define AGC_SAMPLE_NS     200
`define AGC_SAMPLE_CYC    ((`AGC_SAMPLE_NS*`AGC_CLK_MHZ)/1000)
`define AGC_STROBE_KHZ    2500
`define AGC_STROBE_CYC    ((`AGC_CLK_MHZ*1000)/`AGC_STROBE_KHZ)

`endif

/* File: rtl/agc_pulse.v */
// one-shot: an active-low pulse of LEN cycles, with a strobe at its end
// assumes trig is a one-cycle pulse on pclk; trig during a pulse is ignored
`default_nettype none

module agc_pulse #(
	parameter LEN = 20
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       trig,
	output reg        pulse_n,
	output reg        done
);

	// length held at the counter's width so the compare stays 16 bits
	localparam [15:0] LEN_C = LEN;
	reg  [15:0] cnt_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r   <= 16'h0000;
			pulse_n <= 1'b1;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!pulse_n) begin
				if (cnt_r == LEN_C - 16'h0001) begin
					pulse_n <= 1'b1;
					done    <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 16'h0001;
				end
			end else if (trig) begin
				pulse_n <= 1'b0;
				cnt_r   <= 16'h0000;
			end
		end
	end

endmodule // agc_pulse

`default_nettype wire
